// ==== dct_coincidence.sv ====
// Time counter, dual-rail coincidence detectors and gated slave trigger outputs.
//
// Behaviour
// - Thirteen comparison stages, one per bit.
// - Stage agrees when both rails match.
// - Any stage mismatch holds match inactive.
// - Separate match lines for each slave.
// - Master trigger clears counter to zero.
// - Counter advances once every 20 microseconds.
// - Match produces the matching slave trigger.
// - Counter keeps running until next master.
// - Trigger only during match and square-wave phase.
// - No match blocks wave, output stays inactive.
// - Second slave output behaves like first.
// - Indicators show counter and delay inputs present.
module dct_coincidence
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              master_trigger,
	input  wire dct_pkg::dct_dual_t first_delay,
	input  wire dct_pkg::dct_dual_t second_delay,
	output logic                   first_slave_trigger,
	output logic                   second_slave_trigger,
	output dct_pkg::dct_ind_t      indicators
);
	import dct_pkg::*;

	// The wave needs at least two clocks per step, and the rails are fixed at thirteen bits.
	if (STEP_CYCLES < 2 || DCT_BITS != 13) begin : g_bad_cfg
		$error("dct_coincidence: unsupported step or width");
	end

	// Reset release through two flip-flops.
	logic rst_meta_n;
	logic rst_s_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_s_n    <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_s_n    <= rst_meta_n;
		end
	end

	// Pin synchronisers; the edge detector looks only at the second stage onward.
	logic      mt_meta;
	logic      mt_sync;
	logic      mt_prev;
	dct_dual_t d1_meta;
	dct_dual_t d1;
	dct_dual_t d2_meta;
	dct_dual_t d2;
	logic      mstr_edge;

	always_ff @(posedge mclk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			mt_meta <= 1'b0;
			mt_sync <= 1'b0;
			mt_prev <= 1'b0;
			d1_meta <= '0;
			d1      <= '0;
			d2_meta <= '0;
			d2      <= '0;
		end else begin
			mt_meta <= master_trigger;
			mt_sync <= mt_meta;
			mt_prev <= mt_sync;
			d1_meta <= first_delay;
			d1      <= d1_meta;
			d2_meta <= second_delay;
			d2      <= d2_meta;
		end
	end

	assign mstr_edge = mt_sync & ~mt_prev;

	// Time counter and step prescaler.
	logic [DCT_BITS-1:0] cnt;
	logic [DCT_BITS-1:0] next_cnt;
	logic [PRE_W-1:0]    pre;
	logic [PRE_W-1:0]    next_pre;
	logic                running;
	logic                next_running;
	logic                step_end;
	logic                sq_active;

	assign step_end  = (pre == PRE_W'(STEP_CYCLES - 1));
	// The square wave shares the step prescaler, so each counter step holds one wave period.
	assign sq_active = (pre < PRE_W'(SQ_ACTIVE_CYCLES));

	always_comb begin
		next_cnt     = cnt;
		next_pre     = pre;
		next_running = running | mstr_edge;
		if (mstr_edge) begin
			next_cnt = COUNT_RESET;
			next_pre = PRE_RESET;
		end else if (step_end) begin
			next_pre = PRE_RESET;
			next_cnt = cnt + DCT_BITS'(1);
		end else begin
			next_pre = pre + PRE_W'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cnt     <= COUNT_RESET;
			pre     <= PRE_RESET;
			running <= 1'b0;
		end else begin
			cnt     <= next_cnt;
			pre     <= next_pre;
			running <= next_running;
		end
	end

	// Comparison stages; the counter presents its own complement rail.
	logic [DCT_BITS-1:0] agree1;
	logic [DCT_BITS-1:0] agree2;
	logic [DCT_BITS-1:0] cnt_cmpl;
	logic                match1;
	logic                match2;

	assign cnt_cmpl = ~cnt;

	for (genvar i = 0; i < DCT_BITS; i++) begin : g_stage
		assign agree1[i] = (cnt[i] == d1.bits[i]) && (cnt_cmpl[i] == d1.cmpl[i]);
		assign agree2[i] = (cnt[i] == d2.bits[i]) && (cnt_cmpl[i] == d2.cmpl[i]);
	end

	assign match1 = &agree1;
	assign match2 = &agree2;

	// Output stages. A delivered pulse arms a lockout until the next master trigger,
	// because the counter wraps and could otherwise coincide again in a long cycle.
	logic fired1;
	logic fired2;
	logic next_fired1;
	logic next_fired2;
	logic gate1;
	logic gate2;
	logic next_trig1;
	logic next_trig2;

	always_comb begin
		gate1 = running & match1 & sq_active;
		gate2 = running & match2 & sq_active;
		next_trig1 = gate1 & ~fired1;
		next_trig2 = gate2 & ~fired2;
		// one pulse per cycle; end of pulse wins over master clear
		next_fired1 = (first_slave_trigger & ~next_trig1) | (fired1 & ~mstr_edge);
		next_fired2 = (second_slave_trigger & ~next_trig2) | (fired2 & ~mstr_edge);
	end

	// Presence: counter running, delay words well formed on both rails.
	dct_ind_t next_ind;

	always_comb begin
		next_ind.counter = running;
		next_ind.first   = ((d1.bits ^ d1.cmpl) == '1);
		next_ind.second  = ((d2.bits ^ d2.cmpl) == '1);
	end

	always_ff @(posedge mclk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			fired1               <= 1'b0;
			fired2               <= 1'b0;
			first_slave_trigger  <= 1'b0;
			second_slave_trigger <= 1'b0;
			indicators           <= '0;
		end else begin
			fired1               <= next_fired1;
			fired2               <= next_fired2;
			first_slave_trigger  <= next_trig1;
			second_slave_trigger <= next_trig2;
			indicators           <= next_ind;
		end
	end

	// Checks on the block's own behaviour.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_s_n);

	sequence s_master;
		mstr_edge ##1 (cnt == COUNT_RESET && pre == PRE_RESET);
	endsequence

	sequence s_step;
		(step_end && !mstr_edge) ##1 (pre == PRE_RESET);
	endsequence

	property p_clear;
		mstr_edge |-> s_master;
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared by master");

	property p_step;
		(step_end && !mstr_edge) |-> s_step ##0 (cnt == $past(cnt) + 13'h0001);
	endproperty
	a_step: assert property (p_step) else $error("counter step wrong");

	property p_hold;
		(!step_end && !mstr_edge) |=> $stable(cnt);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved mid-step");

	property p_match1;
		match1 |-> (d1.bits == cnt && d1.cmpl == ~cnt);
	endproperty
	a_match1: assert property (p_match1) else $error("first match without agreement");

	property p_miss2;
		(d2.bits != cnt || d2.cmpl != ~cnt) |-> !match2;
	endproperty
	a_miss2: assert property (p_miss2) else $error("second match despite mismatch");

	property p_trig1;
		first_slave_trigger |-> $past(match1) && $past(sq_active) && $past(running);
	endproperty
	a_trig1: assert property (p_trig1) else $error("first trigger without cause");

	property p_block1;
		$past(match1 && running && !fired1) && !$past(sq_active) |-> !first_slave_trigger;
	endproperty
	a_block1: assert property (p_block1) else $error("first trigger outside wave");

	property p_fire2;
		(gate2 && !fired2) |=> second_slave_trigger;
	endproperty
	a_fire2: assert property (p_fire2) else $error("second trigger missed");

	property p_once1;
		(fired1 && !mstr_edge) |=> !first_slave_trigger;
	endproperty
	a_once1: assert property (p_once1) else $error("second pulse in one cycle");

	property p_ind;
		indicators.counter |-> $past(running);
	endproperty
	a_ind: assert property (p_ind) else $error("counter indicator wrong");

	property p_match2;
		match2 |-> (d2.bits == cnt && d2.cmpl == ~cnt);
	endproperty
	a_match2: assert property (p_match2) else $error("second match without agreement");

	property p_miss1;
		(d1.bits != cnt || d1.cmpl != ~cnt) |-> !match1;
	endproperty
	a_miss1: assert property (p_miss1) else $error("first match despite mismatch");

	property p_trig2;
		second_slave_trigger |-> $past(match2) && $past(sq_active) && $past(running);
	endproperty
	a_trig2: assert property (p_trig2) else $error("second trigger without cause");

	property p_block2;
		$past(match2 && running && !fired2) && !$past(sq_active) |-> !second_slave_trigger;
	endproperty
	a_block2: assert property (p_block2) else $error("second trigger outside wave");

	property p_fire1;
		(gate1 && !fired1) |=> first_slave_trigger;
	endproperty
	a_fire1: assert property (p_fire1) else $error("first trigger missed");

	property p_once2;
		(fired2 && !mstr_edge) |=> !second_slave_trigger;
	endproperty
	a_once2: assert property (p_once2) else $error("second slave pulsed twice");

	property p_ind1;
		indicators.first == $past(&(d1.bits ^ d1.cmpl));
	endproperty
	a_ind1: assert property (p_ind1) else $error("first word indicator wrong");

	property p_ind2;
		indicators.second == $past(&(d2.bits ^ d2.cmpl));
	endproperty
	a_ind2: assert property (p_ind2) else $error("second word indicator wrong");

	// Before the first master trigger the count means nothing, so no trigger may leave.
	property p_quiet;
		!running |=> !first_slave_trigger && !second_slave_trigger;
	endproperty
	a_quiet: assert property (p_quiet) else $error("trigger before master");

endmodule

// ==== dct_pkg.sv ====
// Constants and carrier types for the delay coincidence trigger.
package dct_pkg;

	localparam int          DCT_BITS        = 13;
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          STEP_TIME_NS    = 20000;
	localparam int          STEP_CYCLES     = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam int          SQ_ACTIVE_CYCLES = STEP_CYCLES / 2;
	localparam int          PRE_W           = $clog2(STEP_CYCLES);
	localparam logic [12:0] COUNT_RESET     = 13'h0000;
	localparam logic [PRE_W-1:0] PRE_RESET  = '0;

	// One delay or counter word carried on true and complement rails.
	typedef struct packed {
		logic [DCT_BITS-1:0] bits;
		logic [DCT_BITS-1:0] cmpl;
	} dct_dual_t;

	// The three presence indicators.
	typedef struct packed {
		logic counter;
		logic first;
		logic second;
	} dct_ind_t;

endpackage

// ==== dct_enc.sv ====
// Shaft encoder stand-in that drives one dual-rail delay word.
module dct_enc
(
	input  wire logic         mclk,
	input  wire logic [12:0]  value,
	input  wire logic         break_low,
	output dct_pkg::dct_dual_t word
);
	timeunit 1ns;
	timeprecision 1ns;
	import dct_pkg::*;

	// Rails change just after an edge, like the real encoder settling after a slew.
	always_ff @(posedge mclk) begin
		word.bits[12:1] <= value[12:1];
		word.cmpl[12:1] <= ~value[12:1];
		// lowest pair from its own driver
		word.bits[0] <= value[0];
		word.cmpl[0] <= break_low ? value[0] : ~value[0];
	end
endmodule

// ==== tb.sv ====
// Self-checking bench for the delay coincidence trigger.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dct_pkg::*;

	logic        mclk;
	logic        rst_n;
	logic        master_trigger;
	logic [12:0] d1;
	logic [12:0] d2;
	logic        brk1;
	logic        brk2;
	dct_dual_t   w1;
	dct_dual_t   w2;
	logic        t1;
	logic        t2;
	dct_ind_t    ind;
	int          fail_count;
	int          checks;

	dct_enc enc1 (.mclk(mclk), .value(d1), .break_low(brk1), .word(w1));
	dct_enc enc2 (.mclk(mclk), .value(d2), .break_low(brk2), .word(w2));

	dct_coincidence dut (
		.mclk                (mclk),
		.rst_n               (rst_n),
		.master_trigger      (master_trigger),
		.first_delay         (w1),
		.second_delay        (w2),
		.first_slave_trigger (t1),
		.second_slave_trigger(t2),
		.indicators          (ind)
	);

	always #50 mclk = ~mclk;

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_ind(input dct_ind_t got, input dct_ind_t exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t indicators %b expected %b", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// A step of -1 means that slave must stay silent for the whole master cycle.
	// Anything but a clean low counts as high, so an unknown output cannot pass.
	// Two sync stages, the counter clear and the output register put a zero-step
	// trigger four edges after the pin rises.
	task automatic run(input int n, input int s1, input int s2);
		int   r1, r2, n1, n2, p1, p2;
		logic o1, o2;
		r1 = -1;
		r2 = -1;
		n1 = 0;
		n2 = 0;
		p1 = 0;
		p2 = 0;
		o1 = 1'b0;
		o2 = 1'b0;
		@(posedge mclk);
		master_trigger <= 1'b1;
		for (int k = 1; k <= n; k++) begin
			@(posedge mclk);
			if (k == 4) begin
				master_trigger <= 1'b0;
			end
			#1;
			if (t1 !== 1'b0) begin
				n1++;
				if (!o1) begin
					p1++;
				end
				if (r1 < 0) begin
					r1 = k;
				end
			end
			if (t2 !== 1'b0) begin
				n2++;
				if (!o2) begin
					p2++;
				end
				if (r2 < 0) begin
					r2 = k;
				end
			end
			o1 = (t1 !== 1'b0);
			o2 = (t2 !== 1'b0);
		end
		chk_val(16'(r1), 16'(s1 < 0 ? -1 : 4 + STEP_CYCLES * s1));
		chk_val(16'(r2), 16'(s2 < 0 ? -1 : 4 + STEP_CYCLES * s2));
		chk_val(16'(n1), 16'(s1 < 0 ? 0 : SQ_ACTIVE_CYCLES));
		chk_val(16'(n2), 16'(s2 < 0 ? 0 : SQ_ACTIVE_CYCLES));
		chk_val(16'(p1), 16'(s1 < 0 ? 0 : 1));
		chk_val(16'(p2), 16'(s2 < 0 ? 0 : 1));
	endtask

	// Idle after power-up: no master yet, both all-zero words well formed.
	task automatic scen_idle;
		@(negedge mclk);
		chk_ind(ind, 3'h3);
		chk_val(16'({t1, t2}), 16'h0000);
	endtask

	task automatic scen_two_slaves;
		@(posedge mclk);
		d1 <= 13'h0001;
		d2 <= 13'h0003;
		repeat (5) @(posedge mclk);
		run(900, 1, 3);
		@(negedge mclk);
		chk_ind(ind, 3'h7);
	endtask

	// A zero word fires in the very first step, so the clear must land at zero.
	task automatic scen_restart;
		@(posedge mclk);
		d1 <= 13'h0000;
		d2 <= 13'h000c;
		repeat (5) @(posedge mclk);
		run(2700, 0, 12);
	endtask

	// Equal rails on the lowest pair of the first word must never match.
	task automatic scen_broken_rail;
		@(posedge mclk);
		brk1 <= 1'b1;
		d1   <= 13'h0002;
		d2   <= 13'h0002;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		chk_ind(ind, 3'h5);
		run(800, -1, 2);
	endtask

	// Reset in the middle of a pulse; afterwards nothing fires until a new master.
	task automatic scen_mid_reset;
		int busy;
		busy = 0;
		@(posedge mclk);
		master_trigger <= 1'b1;
		repeat (4) @(posedge mclk);
		master_trigger <= 1'b0;
		repeat (445) @(posedge mclk);
		@(negedge mclk);
		chk_val(16'(t2), 16'h0001);
		@(posedge mclk);
		rst_n <= 1'b0;
		@(negedge mclk);
		chk_val(16'({t1, t2}), 16'h0000);
		chk_ind(ind, 3'h0);
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		brk1  <= 1'b0;
		brk2  <= 1'b1;
		for (int k = 0; k < 700; k++) begin
			@(posedge mclk);
			#1;
			if (t1 !== 1'b0 || t2 !== 1'b0) begin
				busy++;
			end
		end
		chk_val(16'(busy), 16'h0000);
		chk_ind(ind, 3'h2);
		run(600, 2, -1);
	endtask

	initial begin
		mclk           = 1'b0;
		rst_n          = 1'b0;
		master_trigger = 1'b0;
		d1             = 13'h0000;
		d2             = 13'h0000;
		brk1           = 1'b0;
		brk2           = 1'b0;
		fail_count     = 0;
		checks         = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		scen_idle();
		scen_two_slaves();
		scen_restart();
		scen_broken_rail();
		scen_mid_reset();
		end_sim();
	end
endmodule
